// ==== rtl/amb_params.svh ====
// Register map, field positions and encodings of the add-on mailbox block
`ifndef AMB_PARAMS_SVH
`define AMB_PARAMS_SVH

// ==========================================================
// Bus geometry
`define AMB_ADDR_W 8
`define AMB_DATA_W 32
`define AMB_BOXES 4
`define AMB_HALF_W 16

// ==========================================================
// Address regions (address bits 7:4) and word index (bits 3:2)
`define AMB_RGN_INB 4'h0
`define AMB_RGN_OUTB 4'h1
`define AMB_RGN_MISC 4'h2
`define AMB_IDX_FLAGS 2'h0
`define AMB_IDX_CTRL 2'h1
`define AMB_IDX_ISTAT 2'h2
`define AMB_IDX_IMASK 2'h3

// ==========================================================
// Field positions
`define AMB_CTRL_FLAG_RST 0
`define AMB_IRQ_FILL 0
`define AMB_IRQ_DRAIN 1
`define AMB_IRQ_W 2

// ==========================================================
// Bus responses
`define AMB_RESP_OKAY 2'h0
`define AMB_RESP_SLVERR 2'h2

`endif

// ==== rtl/amb_pkg.sv ====
// Types shared by the add-on mailbox block
package amb_pkg;
`include "amb_params.svh"

   // ==========================================================
   // Complete register state of the mailbox block
   typedef struct packed {
      logic [`AMB_BOXES-1:0][`AMB_DATA_W-1:0] inb;
      logic [`AMB_BOXES-1:0][`AMB_DATA_W-1:0] outb;
      logic [`AMB_DATA_W-1:0] flags;
      logic [`AMB_IRQ_W-1:0] istat;
      logic [`AMB_IRQ_W-1:0] imask;
      logic aw_got;
      logic [`AMB_ADDR_W-1:0] awaddr;
      logic w_got;
      logic [`AMB_DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [`AMB_DATA_W-1:0] rdata;
      logic [1:0] rresp;
      logic [`AMB_DATA_W-1:0] host_rdata;
   } amb_state_t;

endpackage

// ==== rtl/amb_mailbox.sv ====
// Add-on side mailbox registers with byte fill flags, AXI4-Lite slave
// Operation
// - Add-on side mirrors host-side mailbox flag and access behaviour
// - Flag bits 15:0 show inbound bytes holding unread host data
// - Reading a full inbound byte clears its flag in both views
// - Inbound boxes return a full 32-bit word on read
// - Flag bits 31:16 show outbound bytes the host has not read
// - Writing a still-full outbound byte overwrites it, no error, no stall
// - Outbound boxes take 32-bit writes, each enabled byte stored alone
// - Writing an outbound byte sets its flag in both views
// - Flags read-only; writing one to flag reset clears all flags except any set in that same cycle
// - Four inbound read-only and four outbound read/write boxes
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module amb_mailbox
   import amb_pkg::*;
#(
   parameter int ADDR_W = `AMB_ADDR_W
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // AXI4-Lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Host side mailbox access
   input wire logic host_wr_i,
   input wire logic host_rd_i,
   input wire logic [1:0] host_box_i,
   input wire logic [3:0] host_be_i,
   input wire logic [31:0] host_wdata_i,
   input wire logic host_flag_rst_i,
   output logic [31:0] host_rdata_o,
   output logic [31:0] host_mailbox_fill_flags_o,
   // Interrupt
   output logic irq_o
);

   // ==========================================================
   // State
   amb_state_t q;
   amb_state_t n;

   logic ar_hs;
   logic [3:0] ar_rgn;
   logic [1:0] ar_idx;
   logic wr_exec;
   logic [3:0] wr_rgn;
   logic [1:0] wr_idx;
   logic wr_mapped;
   logic rd_mapped;
   logic flag_rst;
   logic ev_fill;
   logic ev_drain;
   logic [15:0] in_set;
   logic [15:0] in_rdclr;
   logic [15:0] out_set;
   logic [15:0] out_rdclr;

   // ==========================================================
   // Decode
   // Write executes from captured address and data, so AW and W may come in any order
   assign wr_exec = q.aw_got && q.w_got;
   assign wr_rgn = q.awaddr[7:4];
   assign wr_idx = q.awaddr[3:2];
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   assign ar_rgn = s_axi_araddr[7:4];
   assign ar_idx = s_axi_araddr[3:2];
   assign wr_mapped = (wr_rgn == `AMB_RGN_INB) || (wr_rgn == `AMB_RGN_OUTB)
      || (wr_rgn == `AMB_RGN_MISC);
   assign rd_mapped = (ar_rgn == `AMB_RGN_INB) || (ar_rgn == `AMB_RGN_OUTB)
      || (ar_rgn == `AMB_RGN_MISC);

   // ==========================================================
   // Per-box flag set and clear masks
   for (genvar k = 0; k < `AMB_BOXES; k++) begin : g_box
      // Flag index is box * 4 + byte within box
      assign in_set[4*k +: 4] = (host_wr_i && host_box_i == 2'(k)) ? host_be_i : 4'h0;
      assign out_rdclr[4*k +: 4] = (host_rd_i && host_box_i == 2'(k)) ? host_be_i : 4'h0;
      // A word read drains all four bytes since AXI4-Lite reads carry no strobes
      assign in_rdclr[4*k +: 4] = (ar_hs && ar_rgn == `AMB_RGN_INB && ar_idx == 2'(k))
         ? 4'hf : 4'h0;
      assign out_set[4*k +: 4] = (wr_exec && wr_rgn == `AMB_RGN_OUTB && wr_idx == 2'(k))
         ? q.wstrb : 4'h0;
   end

   assign flag_rst = host_flag_rst_i || (wr_exec && wr_rgn == `AMB_RGN_MISC
      && wr_idx == `AMB_IDX_CTRL && q.wstrb[0] && q.wdata[`AMB_CTRL_FLAG_RST]);
   assign ev_fill = |in_set;
   assign ev_drain = |(out_rdclr & q.flags[31:16]);

   // ==========================================================
   // Next state
   always_comb begin
      n = q;
      // Write channel capture
      if (s_axi_awvalid && s_axi_awready) begin
         n.aw_got = 1'b1;
         n.awaddr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         n.w_got = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (wr_exec) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = wr_mapped ? `AMB_RESP_OKAY : `AMB_RESP_SLVERR;
         // Inbound boxes and flags ignore bus writes
         if (wr_rgn == `AMB_RGN_OUTB) begin
            for (int b = 0; b < 4; b++) begin
               if (q.wstrb[b]) begin
                  // Full bytes are overwritten without stalling
                  n.outb[wr_idx][8*b +: 8] = q.wdata[8*b +: 8];
               end
            end
         end
         if (wr_rgn == `AMB_RGN_MISC && wr_idx == `AMB_IDX_IMASK && q.wstrb[0]) begin
            n.imask = q.wdata[`AMB_IRQ_W-1:0];
         end
      end
      // Host writes land in the inbound boxes
      for (int b = 0; b < 4; b++) begin
         if (host_wr_i && host_be_i[b]) begin
            n.inb[host_box_i][8*b +: 8] = host_wdata_i[8*b +: 8];
         end
      end
      if (host_rd_i) begin
         n.host_rdata = q.outb[host_box_i];
      end
      // Read channel
      if (s_axi_rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (ar_hs) begin
         n.rvalid = 1'b1;
         n.rresp = rd_mapped ? `AMB_RESP_OKAY : `AMB_RESP_SLVERR;
         n.rdata = 32'h0;
         case (ar_rgn)
            `AMB_RGN_INB: n.rdata = q.inb[ar_idx];
            `AMB_RGN_OUTB: n.rdata = q.outb[ar_idx];
            `AMB_RGN_MISC: begin
               case (ar_idx)
                  `AMB_IDX_FLAGS: n.rdata = q.flags;
                  `AMB_IDX_ISTAT: n.rdata = {30'h0, q.istat};
                  `AMB_IDX_IMASK: n.rdata = {30'h0, q.imask};
                  default: n.rdata = 32'h0;
               endcase
            end
            default: n.rdata = 32'h0;
         endcase
      end
      // Sets win over every clear in the same cycle
      n.flags = (q.flags & ~{out_rdclr, in_rdclr} & ~{32{flag_rst}})
         | {out_set, in_set};
      n.istat = q.istat;
      if (wr_exec && wr_rgn == `AMB_RGN_MISC && wr_idx == `AMB_IDX_ISTAT && q.wstrb[0]) begin
         n.istat = q.istat & ~q.wdata[`AMB_IRQ_W-1:0];
      end
      n.istat[`AMB_IRQ_FILL] = n.istat[`AMB_IRQ_FILL] | ev_fill;
      n.istat[`AMB_IRQ_DRAIN] = n.istat[`AMB_IRQ_DRAIN] | ev_drain;
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // ==========================================================
   // Outputs
   assign s_axi_awready = !q.aw_got && !q.bvalid;
   assign s_axi_wready = !q.w_got && !q.bvalid;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign host_rdata_o = q.host_rdata;
   assign host_mailbox_fill_flags_o = q.flags;
   assign irq_o = |(q.istat & q.imask);

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_inb_fill_flag: assert property (host_wr_i |=>
      ((q.flags[15:0] & $past(in_set)) == $past(in_set)))
      else $error("Host write did not set inbound flag");

   a_inb_read_clear: assert property (ar_hs && ar_rgn == `AMB_RGN_INB && !host_wr_i |=>
      ((q.flags[15:0] & $past(in_rdclr)) == 16'h0) && q.rvalid)
      else $error("Inbound read did not clear flags");

   a_inb_read_data: assert property (ar_hs && ar_rgn == `AMB_RGN_INB |=>
      q.rvalid && q.rdata == $past(q.inb[ar_idx]))
      else $error("Inbound read returned wrong word");

   a_out_flag_set: assert property (wr_exec && wr_rgn == `AMB_RGN_OUTB |=>
      ((q.flags[31:16] & $past(out_set)) == $past(out_set)) && s_axi_bvalid)
      else $error("Outbound write did not set flag");

   a_out_overwrite: assert property (wr_exec && wr_rgn == `AMB_RGN_OUTB && q.wstrb == 4'hf |=>
      q.outb[$past(wr_idx)] == $past(q.wdata))
      else $error("Outbound word not overwritten");

   a_out_strobe_keep: assert property (wr_exec && wr_rgn == `AMB_RGN_OUTB && !q.wstrb[3] |=>
      q.outb[$past(wr_idx)][31:24] == $past(q.outb[wr_idx][31:24]))
      else $error("Disabled byte lane was written");

   a_flag_reset_all: assert property (flag_rst && in_set == 16'h0 && out_set == 16'h0 |=>
      q.flags == 32'h0)
      else $error("Flag reset left flags set");

   a_flags_read_only: assert property (wr_exec && wr_rgn == `AMB_RGN_MISC
      && wr_idx == `AMB_IDX_FLAGS && !host_wr_i |=> (q.flags & ~$past(q.flags)) == 32'h0)
      else $error("Write to flags set a flag");

   a_inb_read_only: assert property (wr_exec && wr_rgn == `AMB_RGN_INB && !host_wr_i |=>
      q.inb == $past(q.inb))
      else $error("Bus write changed inbound box");

   a_host_drain: assert property (host_rd_i |=>
      (q.flags[31:16] & $past(out_rdclr) & ~$past(out_set)) == 16'h0)
      else $error("Host read did not clear outbound flag");

   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("Write response dropped early");

   // ==========================================================
   // Bus responses and read data
   a_wr_resp_stable: assert property (s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp))
      else $error("Write response code changed while pending");

   a_good_wr_resp: assert property (wr_exec && wr_mapped |=>
      s_axi_bvalid && s_axi_bresp == `AMB_RESP_OKAY)
      else $error("Mapped write answered with an error");

   a_bad_wr_resp: assert property (wr_exec && !wr_mapped |=>
      s_axi_bvalid && s_axi_bresp == `AMB_RESP_SLVERR && q.outb == $past(q.outb))
      else $error("Unmapped write was not refused");

   a_rd_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("Read data changed before it was taken");

   a_bad_rd_resp: assert property (ar_hs && !rd_mapped |=>
      s_axi_rvalid && s_axi_rresp == `AMB_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("Unmapped read was not refused");

   a_out_read_data: assert property (ar_hs && ar_rgn == `AMB_RGN_OUTB |=>
      s_axi_rdata == $past(q.outb[ar_idx]) && s_axi_rresp == `AMB_RESP_OKAY)
      else $error("Outbound read returned wrong word");

   a_flags_read_data: assert property (ar_hs && ar_rgn == `AMB_RGN_MISC
      && ar_idx == `AMB_IDX_FLAGS |=> s_axi_rdata == $past(q.flags))
      else $error("Flag register read returned wrong value");

   a_ctrl_reads_zero: assert property (ar_hs && ar_rgn == `AMB_RGN_MISC
      && ar_idx == `AMB_IDX_CTRL |=> s_axi_rdata == 32'h0)
      else $error("Write-only control word read back nonzero");

   // ==========================================================
   // Flag and data paths
   // A flag may only drop for a named cause; a stray clear would lose host data
   a_inb_flag_sticky: assert property (!host_wr_i && !ar_hs && !flag_rst |=>
      q.flags[15:0] == $past(q.flags[15:0]))
      else $error("Inbound flags moved with no cause");

   a_out_flag_sticky: assert property (!host_rd_i && !wr_exec && !flag_rst |=>
      q.flags[31:16] == $past(q.flags[31:16]))
      else $error("Outbound flags moved with no cause");

   a_no_stray_clear: assert property (!flag_rst && !host_rd_i && !ar_hs |=>
      (q.flags & $past(q.flags)) == $past(q.flags))
      else $error("Flag cleared with no read or reset");

   a_host_read_data: assert property (host_rd_i |=>
      host_rdata_o == $past(q.outb[host_box_i]))
      else $error("Host read returned wrong outbound word");

   a_host_data_hold: assert property (!host_rd_i |=> host_rdata_o == $past(host_rdata_o))
      else $error("Host read data changed with no read");

   a_host_write_data: assert property (host_wr_i && host_be_i[0] |=>
      q.inb[$past(host_box_i)][7:0] == $past(host_wdata_i[7:0]))
      else $error("Host write did not land in inbound box");

   a_imask_write: assert property (wr_exec && wr_rgn == `AMB_RGN_MISC
      && wr_idx == `AMB_IDX_IMASK && q.wstrb[0] |=> q.imask == $past(q.wdata[`AMB_IRQ_W-1:0]))
      else $error("Interrupt mask write lost");

   // Checked only in quiet cycles, since a new event in the same cycle must win
   a_istat_w1c: assert property (wr_exec && wr_rgn == `AMB_RGN_MISC
      && wr_idx == `AMB_IDX_ISTAT && q.wstrb[0] && !ev_fill && !ev_drain |=>
      (q.istat & $past(q.wdata[`AMB_IRQ_W-1:0])) == 2'h0)
      else $error("Interrupt status not cleared by a one");

   a_fill_event: assert property (host_wr_i && host_be_i != 4'h0 |=> q.istat[`AMB_IRQ_FILL])
      else $error("Host fill did not raise status");

   a_drain_event: assert property (ev_drain |=> q.istat[`AMB_IRQ_DRAIN])
      else $error("Host drain did not raise status");

   // ==========================================================
   // Coverage of main scenarios
   c_inb_read_full: cover property (ar_hs && ar_rgn == `AMB_RGN_INB && |(in_rdclr & q.flags[15:0]));
   c_out_overwrite: cover property (|(out_set & q.flags[31:16]));
   c_flag_reset: cover property (flag_rst && q.flags != 32'h0);
   c_irq_raise: cover property (!irq_o ##1 irq_o);
   c_reset_with_fill: cover property (flag_rst && in_set != 16'h0);

endmodule

// ==== tb/amb_host_model.sv ====
// Host-side partner model that pulses the mailbox host port
`timescale 1ns/10ps
module amb_host_model (
   // Clock
   input wire logic core_clk_i,
   // Host port
   output logic host_wr_o,
   output logic host_rd_o,
   output logic [1:0] host_box_o,
   output logic [3:0] host_be_o,
   output logic [31:0] host_wdata_o,
   output logic host_flag_rst_o
);
   initial begin
      host_wr_o = 1'b0;
      host_rd_o = 1'b0;
      host_box_o = 2'h0;
      host_be_o = 4'h0;
      host_wdata_o = 32'h0;
      host_flag_rst_o = 1'b0;
   end

   // ==========================================================
   // One access
   // Between pulses the qualifiers show the inverse of the last value, never a stale copy
   task automatic xfer(input logic w, input logic r, input logic [1:0] b, input logic [3:0] e,
                       input logic [31:0] d);
      @(posedge core_clk_i);
      host_wr_o <= w;
      host_rd_o <= r;
      host_box_o <= b;
      host_be_o <= e;
      host_wdata_o <= d;
      @(posedge core_clk_i);
      host_wr_o <= 1'b0;
      host_rd_o <= 1'b0;
      host_box_o <= ~b;
      host_be_o <= ~e;
      host_wdata_o <= ~d;
      @(posedge core_clk_i);
   endtask

   // Flag reset pulse, optionally with a write to box 0 byte 0 in the same cycle
   task automatic wipe(input logic w, input logic [31:0] d);
      @(posedge core_clk_i);
      host_flag_rst_o <= 1'b1;
      host_wr_o <= w;
      host_box_o <= 2'h0;
      host_be_o <= 4'h1;
      host_wdata_o <= d;
      @(posedge core_clk_i);
      host_flag_rst_o <= 1'b0;
      host_wr_o <= 1'b0;
      host_box_o <= 2'h3;
      host_be_o <= 4'he;
      host_wdata_o <= ~d;
      @(posedge core_clk_i);
   endtask
endmodule

// ==== tb/test_amb_mailbox.sv ====
// Self-checking bench for the add-on mailbox block
`timescale 1ns/10ps
module test_amb_mailbox;
   import amb_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic awr, wr, bv, arr, rv, hwr, hrdq, irq, hfr;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rd, hrd, hfl, hwd, v;
   logic [3:0] ws = 4'h0, hbe;
   logic [1:0] bresp, rresp, hbox, r;
   int fails = 0;
   int total_checks = 0;

   always #12.5 clk = ~clk;

   amb_mailbox dut (.core_clk_i(clk), .rst_n_i(rst_n), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
      .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
      .s_axi_rresp(rresp), .host_wr_i(hwr), .host_rd_i(hrdq), .host_box_i(hbox),
      .host_be_i(hbe), .host_wdata_i(hwd), .host_flag_rst_i(hfr), .host_rdata_o(hrd),
      .host_mailbox_fill_flags_o(hfl), .irq_o(irq));

   amb_host_model host (.core_clk_i(clk), .host_wr_o(hwr), .host_rd_o(hrdq), .host_box_o(hbox),
      .host_be_o(hbe), .host_wdata_o(hwd), .host_flag_rst_o(hfr));

   // ==========================================================
   // Checking and bus tasks
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task test_done;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Ready is sampled at the falling edge; it only moves on rising edges
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] resp);
      logic ga, gw, da, dw;
      da = 1'b0;
      dw = 1'b0;
      @(posedge clk);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= d;
      ws <= s;
      br <= 1'b1;
      while (!(da && dw)) begin
         @(negedge clk);
         ga = awv && awr;
         gw = wv && wr;
         @(posedge clk);
         da = da | ga;
         dw = dw | gw;
         if (ga)
            awv <= 1'b0;
         if (gw)
            wv <= 1'b0;
      end
      do @(negedge clk); while (!bv);
      resp = bresp;
      @(posedge clk);
      br <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      logic g;
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rr <= 1'b1;
      do begin
         @(negedge clk);
         g = arv && arr;
         @(posedge clk);
      end while (!g);
      arv <= 1'b0;
      do @(negedge clk); while (!rv);
      d = rd;
      resp = rresp;
      @(posedge clk);
      rr <= 1'b0;
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      axi_rd(a, v, r);
      chk(nm, v, e);
   endtask

   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      axi_wr(a, d, s, r);
      chk("bresp", {30'h0, r}, 32'h0);
   endtask

   // ==========================================================
   // Tests
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk("flags", 8'h20, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
      $display("test reset done");
      host.xfer(1'b1, 1'b0, 2'h1, 4'hf, 32'h89abcdef);
      host.xfer(1'b1, 1'b0, 2'h2, 4'h1, 32'h000000a5);
      rd_chk("flags", 8'h20, 32'h000001f0);
      rd_chk("inbox1", 8'h04, 32'h89abcdef);
      rd_chk("flags", 8'h20, 32'h00000100);
      chk("hostflags", hfl, 32'h00000100);
      wr_ok(8'h04, 32'h0, 4'hf);
      rd_chk("inbox1", 8'h04, 32'h89abcdef);
      rd_chk("inbox2", 8'h08, 32'h000000a5);
      rd_chk("flags", 8'h20, 32'h0);
      $display("test inbound done");
      wr_ok(8'h1c, 32'h44332211, 4'h5);
      rd_chk("flags", 8'h20, 32'h50000000);
      wr_ok(8'h1c, 32'haabbccdd, 4'h1);
      rd_chk("outbox3", 8'h1c, 32'h003300dd);
      chk("hostflags", hfl, 32'h50000000);
      host.xfer(1'b0, 1'b1, 2'h3, 4'h1, 32'h0);
      chk("hostdata", hrd, 32'h003300dd);
      rd_chk("flags", 8'h20, 32'h40000000);
      $display("test outbound done");
      wr_ok(8'h20, 32'hffffffff, 4'hf);
      rd_chk("flags", 8'h20, 32'h40000000);
      wr_ok(8'h24, 32'h0, 4'h1);
      rd_chk("flags", 8'h20, 32'h40000000);
      wr_ok(8'h24, 32'h1, 4'h1);
      rd_chk("flags", 8'h20, 32'h0);
      chk("hostflags", hfl, 32'h0);
      wr_ok(8'h10, 32'h12345678, 4'h3);
      chk("hostflags", hfl, 32'h00030000);
      host.wipe(1'b1, 32'h0000005a);
      rd_chk("flags", 8'h20, 32'h00000001);
      host.wipe(1'b0, 32'h0);
      chk("hostflags", hfl, 32'h0);
      rd_chk("inbox0", 8'h00, 32'h0000005a);
      axi_wr(8'h30, 32'h1, 4'hf, r);
      chk("bresp", {30'h0, r}, 32'h2);
      axi_rd(8'h30, v, r);
      chk("rresp", {30'h0, r}, 32'h2);
      chk("rdata", v, 32'h0);
      $display("test flag reset done");
      chk("irq", {31'h0, irq}, 32'h0);
      wr_ok(8'h2c, 32'h1, 4'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      wr_ok(8'h28, 32'h1, 4'h1);
      chk("irq", {31'h0, irq}, 32'h0);
      rd_chk("istat", 8'h28, 32'h2);
      wr_ok(8'h2c, 32'h3, 4'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      wr_ok(8'h28, 32'h2, 4'h1);
      chk("irq", {31'h0, irq}, 32'h0);
      $display("test interrupt done");
      wr_ok(8'h14, 32'hcafef00d, 4'hf);
      chk("hostflags", hfl, 32'h00f00000);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      chk("hostflags", hfl, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
      rd_chk("outbox1", 8'h14, 32'h0);
      rd_chk("imask", 8'h2c, 32'h0);
      $display("test second reset done");
      test_done;
   end

   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      test_done;
   end
endmodule
